// file: core/pfsk_pkg.sv
// Notes on behaviour
// - While the reset pin is high, in stop mode or not, an interrupt pin delivers its level whenever input is enabled.
// - Port H bit 3 (debug enable) is input with pull-up while reset pin is low.
// - Port I bit 0 is input with pull-up while reset pin is low.
// - Port J bit 0 (boot select) is input with pull-up while reset pin is low.
// - Port J bit 5 is input only, without output, pull or open-drain bits.
// - Reset-disabled pulls are forced off for the whole reset period.
// - The stop-retaining bidirectional pin type has its pull-up forced on and its pull-down forced off during reset.
// - LCD output pins keep driving in stop mode; their pulls are off in reset.
// - Port H select 1: serial 0 tx, rx, clock, serial 1 tx, rx, clock.
// - Port H select 2: infrared and clear-to-send pins; select 3: 16-bit timer outputs.
// - Port I select 1: serial 2, timer-B ch0 capture, serial 30.
// - Port I select 2: infrared 2, clear-to-send 2 and 30; select 3: timers 2 and 5.
// - Port J select 1: two-wire, serial clock, RTC out, timer 3, capture ch1.
// - Port J select 2: interrupt 1, system clock out, low-speed clock input.
// - Bits 31..8 and unimplemented bits read zero; writes to them do nothing.
package pfsk_pkg;

    localparam int NPORT = 5;
    localparam int NKIND = 9;
    localparam int NFUNC = 3;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register kinds and offsets
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        PFSK_DATA, PFSK_CR, PFSK_FR1, PFSK_FR2, PFSK_FR3,
        PFSK_OD, PFSK_PUP, PFSK_PDN, PFSK_IE, PFSK_NONE
    } pfsk_kind_t;

    localparam logic [5:0] OFS_DATA = 6'h00;
    localparam logic [5:0] OFS_CR = 6'h04;
    localparam logic [5:0] OFS_FR1 = 6'h08;
    localparam logic [5:0] OFS_FR2 = 6'h0c;
    localparam logic [5:0] OFS_FR3 = 6'h10;
    localparam logic [5:0] OFS_OD = 6'h28;
    localparam logic [5:0] OFS_PUP = 6'h2c;
    localparam logic [5:0] OFS_PDN = 6'h30;
    localparam logic [5:0] OFS_IE = 6'h38;

    // Port number sits above the 64-byte register group of each port
    localparam int PORT_LSB = 6;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Implemented bits, port order G, H, I, J, K
    // ----------------------------------------------------------------
    localparam logic [7:0] PIN_MASK [NPORT] = '{8'h01, 8'h3f, 8'h7f, 8'h3f, 8'h03};
    localparam logic [7:0] CTL_MASK [NPORT] = '{8'h01, 8'h3f, 8'h7f, 8'h1f, 8'h03};
    localparam logic [7:0] FR_MASK [NPORT][NFUNC] = '{
        '{8'h01, 8'h01, 8'h00}, '{8'h3f, 8'h2d, 8'h24}, '{8'h7f, 8'h45, 8'h44},
        '{8'h3f, 8'h34, 8'h00}, '{8'h03, 8'h00, 8'h00}};
    // Selected functions that drive the pin; the rest take the pin level
    localparam logic [7:0] OUT_FUNC [NPORT][NFUNC] = '{
        '{8'h01, 8'h00, 8'h00}, '{8'h2d, 8'h09, 8'h24}, '{8'h55, 8'h01, 8'h44},
        '{8'h1f, 8'h10, 8'h00}, '{8'h02, 8'h00, 8'h00}};

    // ----------------------------------------------------------------
    // Pin types
    // ----------------------------------------------------------------
    localparam logic [7:0] IRQ_TYPE [NPORT] = '{8'h01, 8'h00, 8'h00, 8'h04, 8'h01};
    localparam logic [7:0] RETAIN_TYPE [NPORT] = '{8'h00, 8'h08, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] LCD_TYPE [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

endpackage

// file: core/pfsk_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pfsk_port_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [pfsk_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pfsk_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pfsk_pkg::DATA_W-1:0] reg_rdata,
    // System state
    input wire logic reset_pin_n,
    input wire logic stop_mode,
    // Pads, index [port][bit], port 0 is G
    input wire logic [pfsk_pkg::NPORT-1:0][7:0] pad_in,
    output logic [pfsk_pkg::NPORT-1:0][7:0] pad_out,
    output logic [pfsk_pkg::NPORT-1:0][7:0] pad_oe_n,
    output logic [pfsk_pkg::NPORT-1:0][7:0] pad_pull_up,
    output logic [pfsk_pkg::NPORT-1:0][7:0] pad_pull_down,
    // Peripheral side, index [function register][port][bit]
    input wire logic [pfsk_pkg::NFUNC-1:0][pfsk_pkg::NPORT-1:0][7:0] func_out,
    output logic [pfsk_pkg::NFUNC-1:0][pfsk_pkg::NPORT-1:0][7:0] func_in,
    // Interrupt and strap levels
    output logic ext_irq_1,
    output logic ext_irq_2,
    output logic ext_irq_3,
    output logic debug_enable_n
);
    import pfsk_pkg::*;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic pfsk_kind_t decode_kind(input logic [5:0] ofs);
        pfsk_kind_t k;
        k = PFSK_NONE;
        case (ofs)
            OFS_DATA: k = PFSK_DATA;
            OFS_CR: k = PFSK_CR;
            OFS_FR1: k = PFSK_FR1;
            OFS_FR2: k = PFSK_FR2;
            OFS_FR3: k = PFSK_FR3;
            OFS_OD: k = PFSK_OD;
            OFS_PUP: k = PFSK_PUP;
            OFS_PDN: k = PFSK_PDN;
            OFS_IE: k = PFSK_IE;
            default: k = PFSK_NONE;
        endcase
        return k;
    endfunction

    function automatic logic [7:0] reg_mask(input int p, input int k);
        logic [7:0] m;
        m = CTL_MASK[p];
        if (k == int'(PFSK_DATA) || k == int'(PFSK_IE)) begin
            m = PIN_MASK[p];
        end else if (k == int'(PFSK_FR1)) begin
            m = FR_MASK[p][0];
        end else if (k == int'(PFSK_FR2)) begin
            m = FR_MASK[p][1];
        end else if (k == int'(PFSK_FR3)) begin
            m = FR_MASK[p][2];
        end
        return m;
    endfunction

    logic [2:0] port_sel;
    logic port_ok;
    pfsk_kind_t wr_kind;
    pfsk_kind_t rd_kind;
    logic in_reset;

    assign port_sel = reg_addr[PORT_LSB+2:PORT_LSB];
    assign port_ok = (reg_addr[ADDR_W-1:PORT_LSB] < 3'(NPORT));
    assign wr_kind = decode_kind(reg_addr[5:0]);
    assign rd_kind = decode_kind(reg_addr[5:0]);
    assign in_reset = rst | ~reset_pin_n;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] regs [NPORT][NKIND];
    logic [NPORT-1:0][7:0] in_lvl;
    logic [NPORT-1:0][7:0] data_view;

    for (genvar p = 0; p < NPORT; p++) begin : g_reg_p
        for (genvar k = 0; k < NKIND; k++) begin : g_reg_k
            logic hit;
            assign hit = reg_wr && port_ok && (port_sel == 3'(p))
                && (wr_kind == pfsk_kind_t'(k));
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    regs[p][k] <= REG_RESET;
                end else if (hit) begin
                    regs[p][k] <= reg_wdata[7:0] & reg_mask(p, k);
                end
            end
        end
        // Input level where enabled, written value where driven with input disabled
        assign data_view[p] = (in_lvl[p] | (~regs[p][PFSK_IE] & regs[p][PFSK_CR]
            & regs[p][PFSK_DATA])) & PIN_MASK[p];
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_byte;
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        rd_byte = 8'h00;
        if (port_ok && rd_kind == PFSK_DATA) begin
            rd_byte = data_view[port_sel];
        end else if (port_ok && rd_kind != PFSK_NONE) begin
            rd_byte = regs[port_sel][rd_kind];
        end
    end

    assign next_rdata = {24'h000000, rd_byte};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin routing
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NPORT; p++) begin : g_pin_p
        for (genvar b = 0; b < 8; b++) begin : g_pin_b
            logic s1, s2, s3, o1, o2, o3;
            logic out_val, od, drive, keep_out, keep_in, ie_eff, in_ok;

            // Lowest function register wins
            assign s1 = regs[p][PFSK_FR1][b];
            assign s2 = regs[p][PFSK_FR2][b] & ~s1;
            assign s3 = regs[p][PFSK_FR3][b] & ~s1 & ~s2;
            assign o1 = s1 & OUT_FUNC[p][0][b];
            assign o2 = s2 & OUT_FUNC[p][1][b];
            assign o3 = s3 & OUT_FUNC[p][2][b];
            assign out_val = o1 ? func_out[0][p][b] :
                o2 ? func_out[1][p][b] :
                o3 ? func_out[2][p][b] : regs[p][PFSK_DATA][b];

            // Stop-mode retention classes
            assign keep_out = RETAIN_TYPE[p][b] | LCD_TYPE[p][b];
            assign keep_in = RETAIN_TYPE[p][b] | IRQ_TYPE[p][b];

            assign od = regs[p][PFSK_OD][b];
            assign drive = regs[p][PFSK_CR][b] & ~in_reset & (~stop_mode | keep_out);
            assign pad_out[p][b] = out_val & ~od;
            assign pad_oe_n[p][b] = ~(drive & ~(od & out_val));

            // Strap pins are inputs with pull-up while the reset pin is low
            assign ie_eff = in_reset ? RETAIN_TYPE[p][b] : regs[p][PFSK_IE][b];
            assign in_ok = ie_eff & (~stop_mode | keep_in);
            assign in_lvl[p][b] = pad_in[p][b] & in_ok;

            assign func_in[0][p][b] = in_lvl[p][b] & s1 & ~OUT_FUNC[p][0][b];
            assign func_in[1][p][b] = in_lvl[p][b] & s2 & ~OUT_FUNC[p][1][b];
            assign func_in[2][p][b] = in_lvl[p][b] & s3 & ~OUT_FUNC[p][2][b];

            // Pulls forced during reset by pin type
            assign pad_pull_up[p][b] = in_reset ? RETAIN_TYPE[p][b] : regs[p][PFSK_PUP][b];
            assign pad_pull_down[p][b] = in_reset ? 1'b0 : regs[p][PFSK_PDN][b];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt levels ignore the function select
    // ----------------------------------------------------------------
    assign ext_irq_2 = in_lvl[0][0];
    assign ext_irq_1 = in_lvl[3][2];
    assign ext_irq_3 = in_lvl[4][0];
    assign debug_enable_n = pad_in[1][3];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic [7:0] free_pulls;
    always_comb begin
        free_pulls = 8'h00;
        for (int p = 0; p < NPORT; p++) begin
            free_pulls = free_pulls | ((pad_pull_up[p] | pad_pull_down[p]) & ~RETAIN_TYPE[p]);
        end
    end

    AST_IRQ_FOLLOWS: assert property (
        (reset_pin_n && !stop_mode && regs[0][PFSK_IE][0]) |-> (ext_irq_2 == pad_in[0][0]))
        else $error("interrupt 2 level not delivered");
    AST_PH3_STRAP: assert property (
        !reset_pin_n |-> (pad_pull_up[1][3] && pad_oe_n[1][3] && debug_enable_n == pad_in[1][3]))
        else $error("debug strap not input with pull-up in reset");
    AST_PI0_STRAP: assert property (
        !reset_pin_n |-> (pad_pull_up[2][0] && pad_oe_n[2][0] && !pad_pull_down[2][0]))
        else $error("port I bit 0 not input with pull-up in reset");
    AST_PJ0_STRAP: assert property (
        !reset_pin_n |-> (pad_pull_up[3][0] && pad_oe_n[3][0]))
        else $error("boot strap not input with pull-up in reset");
    AST_PJ5_INPUT: assert property (
        pad_oe_n[3][5] && !pad_pull_up[3][5] && !pad_pull_down[3][5])
        else $error("port J bit 5 drives or pulls");
    AST_PULLS_OFF: assert property (
        !reset_pin_n |-> (free_pulls == 8'h00))
        else $error("pull left on during reset");
    AST_RETAIN_PULL: assert property (
        !reset_pin_n |-> (pad_pull_up[1][3] && pad_pull_up[2][0] && pad_pull_up[3][0]))
        else $error("retaining pins lost forced pull-up");
    AST_IRQ_STOP: assert property (
        (reset_pin_n && stop_mode && regs[3][PFSK_IE][2]) |-> (ext_irq_1 == pad_in[3][2]))
        else $error("interrupt 1 input lost in stop");
    AST_READ_ZERO: assert property (
        (reg_rd && reg_addr == 9'h000) |=> (reg_rdata[31:1] == 31'h0))
        else $error("unimplemented bits read nonzero");
    AST_PRIORITY: assert property (
        (regs[0][PFSK_FR1][0] && regs[0][PFSK_FR2][0] && regs[0][PFSK_CR][0]
        && !regs[0][PFSK_OD][0]) |-> (pad_out[0][0] == func_out[0][0][0] && !func_in[1][0][0]))
        else $error("function priority broken on port G");
    AST_DATA_READ: assert property (
        (reg_rd && reg_addr == 9'h040 && !regs[1][PFSK_IE][0] && !regs[1][PFSK_CR][0])
        |=> (reg_rdata[0] == 1'b0))
        else $error("disabled data bit reads nonzero");

    // ----------------------------------------------------------------
    // Per-pin checks
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NPORT; p++) begin : g_chk_p
        AST_REG_MASK: assert property (
            (((regs[p][PFSK_CR] | regs[p][PFSK_OD] | regs[p][PFSK_PUP] | regs[p][PFSK_PDN])
            & ~CTL_MASK[p]) == 8'h00))
            else $error("control bit set where no pin exists");
        for (genvar b = 0; b < 8; b++) begin : g_chk_b
            AST_RESET_RELEASE: assert property (
                in_reset |-> (pad_oe_n[p][b] && !pad_pull_down[p][b]
                && pad_pull_up[p][b] == RETAIN_TYPE[p][b]))
                else $error("pin not released during reset");
            AST_STOP_OUTPUT: assert property (
                (stop_mode && !(RETAIN_TYPE[p][b] | LCD_TYPE[p][b])) |-> pad_oe_n[p][b])
                else $error("output left driving in stop");
            AST_STOP_INPUT: assert property (
                (stop_mode && !(RETAIN_TYPE[p][b] | IRQ_TYPE[p][b])) |-> !in_lvl[p][b])
                else $error("input left open in stop");
            AST_ROUTE_OUT: assert property (
                (regs[p][PFSK_FR1][b] && OUT_FUNC[p][0][b] && !regs[p][PFSK_OD][b])
                |-> (pad_out[p][b] == func_out[0][p][b]))
                else $error("select 1 output not routed");
            AST_ROUTE_IN: assert property (
                regs[p][PFSK_FR1][b] |-> (!func_in[1][p][b] && !func_in[2][p][b]))
                else $error("blocked input function reached");
        end
    end

    COV_WRITE_READ: cover property (reg_wr ##1 reg_rd ##1 reg_rdata != 32'h0);
    COV_STOP_IRQ: cover property (stop_mode && ext_irq_3);
    COV_RESET_PIN: cover property ($rose(reset_pin_n));
    COV_OPEN_DRAIN: cover property (regs[2][PFSK_OD][0] && !pad_oe_n[2][0]);

endmodule
`default_nettype wire

// file: sim/pfsk_board.sv
`timescale 1ns/1ps
`default_nettype none
module pfsk_board (
    // Clock
    input wire logic core_clk,
    // Pad side of the port block
    input wire logic [pfsk_pkg::NPORT-1:0][7:0] pad_out,
    input wire logic [pfsk_pkg::NPORT-1:0][7:0] pad_oe_n,
    input wire logic [pfsk_pkg::NPORT-1:0][7:0] pad_pull_up,
    input wire logic [pfsk_pkg::NPORT-1:0][7:0] pad_pull_down,
    // Board drivers
    input wire logic [pfsk_pkg::NPORT-1:0][7:0] ext_en,
    input wire logic [pfsk_pkg::NPORT-1:0][7:0] ext_val,
    output logic [pfsk_pkg::NPORT-1:0][7:0] pad_in
);
    import pfsk_pkg::*;
    // --------
    // Pad level resolution
    // --------
    logic float_pat = 1'b0;
    // Undriven pads wander every cycle instead of keeping a value
    always_ff @(posedge core_clk) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (!pad_oe_n[p][b]) begin
                    pad_in[p][b] = pad_out[p][b];
                end else if (ext_en[p][b]) begin
                    pad_in[p][b] = ext_val[p][b];
                end else if (pad_pull_up[p][b]) begin
                    pad_in[p][b] = 1'b1;
                end else if (pad_pull_down[p][b]) begin
                    pad_in[p][b] = 1'b0;
                end else begin
                    pad_in[p][b] = float_pat ^ b[0];
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pfsk_pkg::*;
    // --------
    // Signals
    // --------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reset_pin_n = 1'b1;
    logic stop_mode = 1'b0;
    logic [NPORT-1:0][7:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down;
    logic [NPORT-1:0][7:0] ext_en = '0;
    logic [NPORT-1:0][7:0] ext_val = '0;
    logic [NFUNC-1:0][NPORT-1:0][7:0] func_out = '0;
    logic [NFUNC-1:0][NPORT-1:0][7:0] func_in;
    logic ext_irq_1, ext_irq_2, ext_irq_3, debug_enable_n;
    int error_cnt = 0;
    int cmp_count = 0;
    localparam logic [7:0] PU_RST [NPORT] = '{8'h00, 8'h08, 8'h01, 8'h01, 8'h00};
    localparam int OFS_ALL [8] = '{OFS_CR, OFS_FR1, OFS_FR2, OFS_FR3, OFS_OD, OFS_PUP,
        OFS_PDN, OFS_IE};
    // Output functions: select register, port, bit
    localparam int RT [9][3] = '{'{0, 0, 0}, '{0, 1, 0}, '{1, 1, 3}, '{2, 1, 5}, '{0, 2, 4},
        '{2, 2, 6}, '{0, 3, 4}, '{1, 3, 4}, '{0, 4, 1}};
    localparam int IT [3][2] = '{'{1, 1}, '{2, 3}, '{3, 5}};
    always #5 core_clk = ~core_clk;
    pfsk_port_ctrl uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reset_pin_n, .stop_mode, .pad_in, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down,
        .func_out, .func_in, .ext_irq_1, .ext_irq_2, .ext_irq_3, .debug_enable_n);
    pfsk_board board (.core_clk, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .ext_en,
        .ext_val, .pad_in);
    // --------
    // Tasks
    // --------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int p, input int o, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= {3'(p), 6'(o)};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input int p, input int o, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= {3'(p), 6'(o)};
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic rst_chk;
        for (int p = 0; p < NPORT; p++) chk(pad_pull_up[p], PU_RST[p]);
        chk(|pad_pull_down, 1'b0);
        chk(&pad_oe_n, 1'b1);
        chk(debug_enable_n, 1'b1);
    endtask
    task automatic do_rst;
        @(posedge core_clk);
        rst <= 1'b1;
        stop_mode <= 1'b0;
        ext_en <= '0;
        func_out <= '0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    initial begin
        logic [7:0] m;
        repeat (7) @(posedge core_clk);
        #1 rst_chk();
        @(posedge core_clk);
        rst <= 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            for (int k = 0; k < 9; k++) rchk(p, k == 8 ? OFS_DATA : OFS_ALL[k], 32'h0);
        end
        $display("test reset values done");
        for (int p = 0; p < NPORT; p++) begin
            for (int k = 0; k < 8; k++) begin
                m = k == 7 ? PIN_MASK[p] : (k > 0 && k < 4) ? FR_MASK[p][k-1] : CTL_MASK[p];
                wr(p, OFS_ALL[k], 32'hffff_ffff);
                rchk(p, OFS_ALL[k], {24'h0, m});
            end
        end
        chk(pad_oe_n[3][5], 1'b1);
        wr(1, 6'h14, 32'hff);
        rchk(1, 6'h14, 32'h0);
        wr(5, OFS_CR, 32'hff);
        rchk(5, OFS_CR, 32'h0);
        $display("test register masks done");
        do_rst();
        wr(1, OFS_PUP, 32'h3f);
        wr(2, OFS_PDN, 32'h7f);
        wr(0, OFS_CR, 32'h1);
        wr(4, OFS_PUP, 32'h3);
        @(posedge core_clk);
        reset_pin_n <= 1'b0;
        #1 rst_chk();
        @(posedge core_clk);
        reset_pin_n <= 1'b1;
        do_rst();
        $display("test reset pin done");
        for (int i = 0; i < 9; i++) begin
            wr(RT[i][1], OFS_CR, 32'h1 << RT[i][2]);
            wr(RT[i][1], OFS_FR1 + 4 * RT[i][0], 32'h1 << RT[i][2]);
            for (int v = 0; v < 2; v++) begin
                @(posedge core_clk);
                func_out[RT[i][0]][RT[i][1]][RT[i][2]] <= v[0];
                #1 chk(pad_out[RT[i][1]][RT[i][2]], v);
            end
            wr(RT[i][1], OFS_FR1 + 4 * RT[i][0], 32'h0);
        end
        do_rst();
        wr(1, OFS_CR, 32'h1);
        wr(1, OFS_FR1, 32'h1);
        wr(1, OFS_FR2, 32'h1);
        for (int v = 0; v < 2; v++) begin
            @(posedge core_clk);
            func_out[0][1][0] <= v[0];
            func_out[1][1][0] <= ~v[0];
            #1 chk(pad_out[1][0], v);
        end
        $display("test function routing done");
        for (int i = 0; i < 3; i++) begin
            wr(IT[i][0], OFS_FR1, 32'h1 << IT[i][1]);
            wr(IT[i][0], OFS_IE, 32'h1 << IT[i][1]);
            for (int v = 0; v < 2; v++) begin
                @(posedge core_clk);
                ext_en[IT[i][0]][IT[i][1]] <= 1'b1;
                ext_val[IT[i][0]][IT[i][1]] <= v[0];
                #1 chk(func_in[0][IT[i][0]][IT[i][1]], v);
            end
        end
        do_rst();
        wr(1, OFS_CR, 32'h0f);
        wr(1, OFS_DATA, 32'h3f);
        wr(1, OFS_IE, 32'h30);
        @(posedge core_clk);
        ext_en[1] <= 8'h30;
        ext_val[1] <= 8'h20;
        rchk(1, OFS_DATA, 32'h2f);
        $display("test input functions and data done");
        do_rst();
        wr(0, OFS_FR1, 32'h1);
        wr(0, OFS_IE, 32'h1);
        wr(3, OFS_IE, 32'h4);
        wr(4, OFS_IE, 32'h1);
        @(posedge core_clk);
        ext_en <= {8'h01, 8'h04, 8'h00, 8'h00, 8'h01};
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            stop_mode <= i[1];
            ext_val <= {5{i[0] ? 8'hff : 8'h00}};
            #1 chk({ext_irq_1, ext_irq_2, ext_irq_3}, {3{i[0]}});
        end
        wr(0, OFS_IE, 32'h0);
        #1 chk(ext_irq_2, 1'b0);
        do_rst();
        wr(1, OFS_CR, 32'h09);
        wr(1, OFS_DATA, 32'h09);
        @(posedge core_clk);
        stop_mode <= 1'b1;
        #1 chk({pad_oe_n[1][3], pad_out[1][3], pad_oe_n[1][0]}, 3'b011);
        $display("test interrupts and stop done");
        final_report();
    end
endmodule
`default_nettype wire
